// ---- src/spias_top.sv ----
// Serial port top: SPI master/slave and audio framing mode.
`timescale 1ns/1ns
module spias_top #(
  parameter int FIFO_DEPTH = spias_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic audio_mode,
  input wire logic master_mode,
  input wire logic one_line,
  input wire logic one_line_tx,
  input wire logic audio_tx,
  input wire logic [2:0] rate_sel,
  input wire logic [4:0] frame_len,
  input wire logic [1:0] audio_std,
  input wire logic slot_32,
  input wire logic [1:0] data_len,
  input wire logic [7:0] rate_div,
  input wire logic mclk_enable,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ack,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ws_in,
  output logic ws_out,
  output logic ws_oe,
  output logic mclk_out
);

  spias_pkg::spias_state_t state_r; // Transfer state
  spias_pkg::spias_std_t std_sel; // Audio standard
  logic [31:0] ff_data; // FIFO head word
  logic ff_valid; // FIFO head present
  logic ff_pop; // Take head word
  logic [4:0] fl; // Clamped frame length
  logic [5:0] slot_len; // Audio slot length
  logic [5:0] dat_len; // Audio sample length
  logic [5:0] wl; // Bits per word on the line
  logic [7:0] dv; // Audio prescaler, never zero
  logic [10:0] half_cyc; // Bit clock half period
  logic [10:0] div_cnt_r; // Bit clock divider
  logic sck_r; // Generated bit clock
  logic sck_prev_r; // Previous sampled bit clock
  logic [7:0] mclk_cnt_r; // Master clock divider
  logic mclk_r; // Master clock
  logic clk_run; // Local bit clock running
  logic mclk_run; // Master clock running
  logic tick; // Bit clock half period done
  logic rise_ev; // Sampling edge
  logic fall_ev; // Launch edge
  logic din; // Selected data input
  logic need_tx; // Words are sent
  logic need_rx; // Words are received
  logic start_ok; // Transfer may begin
  logic word_end; // Last bit of a word on line
  logic load; // Fetch next word
  logic [31:0] sh_r; // Transmit shifter
  logic [31:0] rx_sh_r; // Receive shifter
  logic [31:0] rx_word; // Aligned received word
  logic rx_push; // Received word complete
  logic [5:0] bit_r; // Bit index in word
  logic chan_r; // Audio channel
  logic ws_seen_r; // Last sampled word select
  logic dout_r; // Serial data out
  logic ws_r; // Select or word-select out
  logic [31:0] rx_data_r; // Received word holder
  logic rx_valid_r; // Received word ready
  logic sck_oe_r; // Output enables
  logic mosi_oe_r;
  logic miso_oe_r;
  logic ws_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  spias_fifo #(.W(spias_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(ff_data),
    .out_valid(ff_valid),
    .out_ready(ff_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Word geometry and rates
  always_comb begin
    std_sel = spias_pkg::spias_std_t'(audio_std);
    fl = frame_len;
    if (frame_len < spias_pkg::FRAME_MIN) begin
      fl = spias_pkg::FRAME_MIN;
    end else if (frame_len > spias_pkg::FRAME_MAX) begin
      fl = spias_pkg::FRAME_MAX;
    end
    slot_len = slot_32 ? spias_pkg::SLOT_LONG : spias_pkg::SLOT_SHORT;
    unique case (spias_pkg::spias_dlen_t'(data_len))
      spias_pkg::DLEN_24: dat_len = spias_pkg::DLEN_BITS_24;
      spias_pkg::DLEN_32: dat_len = spias_pkg::DLEN_BITS_32;
      default: dat_len = spias_pkg::DLEN_BITS_16;
    endcase
    if (!slot_32) begin
      dat_len = spias_pkg::DLEN_BITS_16; // Short slot packs 16 bits only
    end
    wl = audio_mode ? slot_len : {1'b0, fl};
    dv = (rate_div == 8'h00) ? 8'h01 : rate_div;
    // Bit clock is 4 or 8 master clock periods in audio mode
    if (audio_mode) begin
      half_cyc = slot_32 ? {1'b0, dv, 2'b00} : {dv, 3'b000};
    end else begin
      half_cyc = 11'h001 << rate_sel;
    end
    if (half_cyc < spias_pkg::MIN_HALF) begin
      half_cyc = spias_pkg::MIN_HALF;
    end
  end

  // Word select level for a given bit and channel
  function automatic logic ws_of(input logic [5:0] b, input logic c);
    logic last;
    last = (b == wl - 6'h01);
    unique case (std_sel)
      spias_pkg::STD_PHILIPS: ws_of = last ? ~c : c;
      spias_pkg::STD_PCM: ws_of = last & c;
      default: ws_of = c;
    endcase
  endfunction : ws_of

  // Place a software word in the transmit shifter
  function automatic logic [31:0] align_tx(input logic [31:0] w);
    if (!audio_mode) begin
      align_tx = w << (6'h20 - {1'b0, fl});
    end else if (std_sel == spias_pkg::STD_LSB) begin
      align_tx = w >> (slot_len - dat_len);
    end else begin
      align_tx = w;
    end
  endfunction : align_tx

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock: local divider in master roles, sampled pin in slave roles
  assign clk_run = master_mode && (state_r == spias_pkg::ST_RUN);
  assign mclk_run = clk_run && audio_mode && mclk_enable;
  assign tick = clk_run && (div_cnt_r == half_cyc - 11'h001);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 11'h000;
      sck_r <= 1'b0;
    end else if (!clk_run) begin
      div_cnt_r <= 11'h000; // Idle low between frames
      sck_r <= 1'b0;
    end else if (tick) begin
      div_cnt_r <= 11'h000;
      sck_r <= ~sck_r;
    end else begin
      div_cnt_r <= div_cnt_r + 11'h001;
    end
  end

  // Master clock for an external audio part
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_r <= 8'h00;
      mclk_r <= 1'b0;
    end else if (!mclk_run) begin
      mclk_cnt_r <= 8'h00;
      mclk_r <= 1'b0;
    end else if (mclk_cnt_r == dv - 8'h01) begin
      mclk_cnt_r <= 8'h00;
      mclk_r <= ~mclk_r;
    end else begin
      mclk_cnt_r <= mclk_cnt_r + 8'h01;
    end
  end

  // Slave edge detection on the synchronous clock pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= sck_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control terms
  always_comb begin
    if (master_mode) begin
      rise_ev = tick && !sck_r;
      fall_ev = tick && sck_r;
    end else begin
      rise_ev = (state_r == spias_pkg::ST_RUN) && sck_in && !sck_prev_r;
      fall_ev = (state_r == spias_pkg::ST_RUN) && !sck_in && sck_prev_r;
    end
    // Audio data rides the first data line; one-line SPI uses the driver's line
    if (audio_mode || (one_line == master_mode)) begin
      din = mosi_in;
    end else begin
      din = miso_in;
    end
    need_tx = audio_mode ? audio_tx : (!one_line || one_line_tx);
    need_rx = audio_mode ? !audio_tx : (!one_line || !one_line_tx);
    if (audio_mode || !master_mode) begin
      start_ok = enable && (audio_mode || !ws_in);
    end else begin
      start_ok = enable && (need_tx ? ff_valid : !rx_valid_r);
    end
    word_end = fall_ev && (bit_r == wl - 6'h01);
    load = ((state_r == spias_pkg::ST_IDLE) && start_ok)
        || ((state_r == spias_pkg::ST_RUN) && word_end && (audio_mode || !master_mode));
    ff_pop = load && need_tx && ff_valid;
    rx_push = rise_ev && need_rx && (bit_r == wl - 6'h01) && (state_r == spias_pkg::ST_RUN);
    if (!audio_mode) begin
      rx_word = rx_sh_r;
    end else if (std_sel == spias_pkg::STD_LSB) begin
      rx_word = {rx_sh_r[30:0], din} << (6'h20 - dat_len);
    end else begin
      rx_word = ({rx_sh_r[30:0], din} << (6'h20 - slot_len)) & ~(32'hFFFFFFFF >> dat_len);
    end
    if (!audio_mode) begin
      rx_word = {rx_sh_r[30:0], din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= spias_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        spias_pkg::ST_IDLE: begin
          if (start_ok) begin
            state_r <= spias_pkg::ST_RUN;
          end
        end
        spias_pkg::ST_RUN: begin
          if (!enable || (!audio_mode && !master_mode && ws_in)) begin
            state_r <= spias_pkg::ST_IDLE; // Disabled or deselected
          end else if (!audio_mode && master_mode && word_end) begin
            state_r <= spias_pkg::ST_DONE;
          end
        end
        spias_pkg::ST_DONE: state_r <= spias_pkg::ST_IDLE;
      endcase
    end
  end

  // Shifters, bit position, channel and word select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 32'h00000000;
      rx_sh_r <= 32'h00000000;
      bit_r <= 6'h00;
      chan_r <= 1'b0;
      ws_seen_r <= 1'b0;
      dout_r <= 1'b0;
      ws_r <= 1'b1;
    end else begin
      if (load) begin
        sh_r <= ff_pop ? align_tx(ff_data) : 32'h00000000;
        dout_r <= ff_pop ? 1'(align_tx(ff_data) >> 31) : 1'b0;
        rx_sh_r <= 32'h00000000;
        bit_r <= 6'h00;
        chan_r <= (state_r == spias_pkg::ST_RUN) ? ~chan_r : 1'b0;
        ws_r <= audio_mode ? ws_of(6'h00, (state_r == spias_pkg::ST_RUN) ? ~chan_r : 1'b0)
                           : 1'b0;
      end else if (fall_ev) begin
        sh_r <= sh_r << 1;
        dout_r <= sh_r[30];
        bit_r <= bit_r + 6'h01;
        if (audio_mode) begin
          ws_r <= ws_of(bit_r + 6'h01, chan_r);
        end
      end else if (rise_ev) begin
        rx_sh_r <= {rx_sh_r[30:0], din};
        ws_seen_r <= ws_in;
        // Audio slave locks its slot to the word-select edges
        if (audio_mode && !master_mode && (ws_in != ws_seen_r)) begin
          if (std_sel == spias_pkg::STD_MSB || std_sel == spias_pkg::STD_LSB) begin
            bit_r <= 6'h00;
            chan_r <= ws_in;
            rx_sh_r <= {31'h00000000, din};
          end else if (std_sel == spias_pkg::STD_PHILIPS || ws_in) begin
            bit_r <= wl - 6'h01;
            chan_r <= (std_sel == spias_pkg::STD_PCM) ? 1'b1 : ~ws_in;
          end
        end
      end else if (state_r != spias_pkg::ST_RUN && !audio_mode) begin
        ws_r <= 1'b1; // Chip select released between frames
      end
    end
  end

  // Received word holder; a new word wins over a same-cycle acknowledge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_r <= 32'h00000000;
      rx_valid_r <= 1'b0;
    end else if (rx_push) begin
      rx_data_r <= rx_word;
      rx_valid_r <= 1'b1;
    end else if (rx_ack) begin
      rx_valid_r <= 1'b0;
    end
  end

  // Pin drivers per role and direction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_oe_r <= 1'b0;
      ws_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= enable && master_mode;
      ws_oe_r <= enable && master_mode;
      mosi_oe_r <= enable && (audio_mode ? audio_tx : (master_mode && need_tx));
      miso_oe_r <= enable && !audio_mode && !master_mode && need_tx && !ws_in;
    end
  end

  assign sck_out = sck_r;
  assign sck_oe = sck_oe_r;
  assign mosi_out = dout_r;
  assign mosi_oe = mosi_oe_r;
  assign miso_out = dout_r;
  assign miso_oe = miso_oe_r;
  assign ws_out = ws_r;
  assign ws_oe = ws_oe_r;
  assign mclk_out = mclk_r;
  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks with their helper counters
  logic [10:0] sck_age_r; // Cycles since bit clock change
  logic [4:0] rise_cnt_r; // Bit clock rises in a frame
  logic [3:0] mrise_r; // Master clock rises per bit period
  logic first_r; // First bit period seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_age_r <= 11'h000;
      rise_cnt_r <= 5'h00;
      mrise_r <= 4'h0;
      first_r <= 1'b0;
    end else begin
      sck_age_r <= (sck_r != sck_out) || tick ? 11'h000
                 : (sck_age_r == 11'h7FF ? sck_age_r : sck_age_r + 11'h001);
      rise_cnt_r <= ws_r ? 5'h00 : rise_cnt_r + 5'((tick && !sck_r) ? 1 : 0);
      mrise_r <= (tick && !sck_r) ? 4'h0
               : mrise_r + 4'((mclk_cnt_r == dv - 8'h01 && !mclk_r && mclk_run) ? 1 : 0);
      first_r <= mclk_run && (first_r || (tick && !sck_r));
    end
  end

  AST_SLAVE_NO_CLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !master_mode |=> !sck_oe)
    else $error("Slave drives the bit clock");

  AST_HALF_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (tick && $stable(rate_sel) && !audio_mode) |-> (12'(sck_age_r) + 12'h001 >= 12'(half_cyc))
      && (half_cyc >= spias_pkg::MIN_HALF))
    else $error("Bit clock half period too short");

  AST_FRAME_BITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && master_mode && !audio_mode && $stable(frame_len) && $rose(ws_out))
      |-> ($past(rise_cnt_r) == fl))
    else $error("SPI frame has the wrong bit count");

  AST_AUDIO_ONE_WAY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && audio_mode && $stable(audio_tx)) |=> !miso_oe && (mosi_oe == $past(audio_tx)))
    else $error("Audio mode data direction wrong");

  AST_WS_AT_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_run && audio_mode && std_sel == spias_pkg::STD_MSB && $changed(ws_out)
      && $past(clk_run)) |-> (bit_r == 6'h00))
    else $error("Word select moved away from slot start");

  AST_MCLK_RATIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mclk_run && first_r && tick && !sck_r && $stable(slot_32) && $stable(rate_div))
      |-> (mrise_r == (slot_32 ? 4'h4 : 4'h8)))
    else $error("Master clock not 256 times sample rate");

  AST_RX_READY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_push |=> rx_valid ##0 (rx_data == $past(rx_word)))
    else $error("Received word not flagged");

endmodule : spias_top

// ---- src/spias_pkg.sv ----
// Constants and types for the serial port with its audio framing mode.
// How it works
// - SPI master or slave, full or half duplex
// - Master bit clock from 3-bit prescaler, eight rates
// - SPI frame length four to sixteen bits
// - Audio mode, master or slave, one direction
// - Audio slots 16 or 32, data 16/24/32
// - Four audio standards with word-select framing
// - Eight-bit linear prescaler sets sample rate
// - Audio master clock at 256 times sample rate
// - Bit rate never above 18 Mbit/s
package spias_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and rates
  localparam int CLK_HZ = 20_000_000; // Reference clock rate
  localparam int MAX_BIT_HZ = 18_000_000; // Fastest serial bit rate
  // Shortest half period of the bit clock, rounded up to whole cycles
  localparam int MIN_HALF_CYC = (CLK_HZ + 2 * MAX_BIT_HZ - 1) / (2 * MAX_BIT_HZ);
  localparam logic [10:0] MIN_HALF = 11'(MIN_HALF_CYC);
  localparam int FS_MIN_HZ = 8_000; // Lowest audio sample rate
  localparam int FS_MAX_HZ = 192_000; // Highest audio sample rate
  localparam int MCLK_RATIO = 256; // Master clock over sample rate

  ////////////////////////////////////////////////////////////////////////////
  // Widths and sizes
  localparam int RATE_SEL_W = 3; // Bit clock selector width
  localparam int FRAME_W = 5; // Frame length field width
  localparam logic [4:0] FRAME_MIN = 5'h04; // Shortest SPI frame
  localparam logic [4:0] FRAME_MAX = 5'h10; // Longest SPI frame
  localparam int DIV_W = 8; // Audio prescaler width
  localparam int WORD_W = 32; // Data word width
  localparam int FIFO_DEPTH = 8; // Transmit FIFO depth
  localparam logic [5:0] SLOT_SHORT = 6'h10; // Short audio slot
  localparam logic [5:0] SLOT_LONG = 6'h20; // Long audio slot
  localparam logic [5:0] DLEN_BITS_16 = 6'h10; // Sample width choices
  localparam logic [5:0] DLEN_BITS_24 = 6'h18;
  localparam logic [5:0] DLEN_BITS_32 = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {STD_PHILIPS, STD_MSB, STD_LSB, STD_PCM} spias_std_t;
  typedef enum logic [1:0] {DLEN_16, DLEN_24, DLEN_32, DLEN_RSV} spias_dlen_t;
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} spias_state_t;

endpackage : spias_pkg

// ---- src/spias_fifo.sv ----
// Small FIFO with registered output stage and registered ready.
`timescale 1ns/1ns
module spias_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [W-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr_r; // Write index
  logic [AW-1:0] rd_ptr_r; // Read index
  logic [AW:0] count_r; // Words held in storage
  logic [AW:0] count_nxt; // Next word count
  logic in_ready_r; // Room for one more word
  logic [W-1:0] out_data_r; // Output stage word
  logic out_valid_r; // Output stage holds a word
  logic push; // Word accepted this cycle
  logic pop_mem; // Word moves to the output stage

  ////////////////////////////////////////////////////////////////////////////
  // Handshake terms
  assign push = in_valid && in_ready_r;
  assign pop_mem = (count_r != '0) && (!out_valid_r || out_ready);

  // Count update
  always_comb begin
    count_nxt = count_r;
    if (push && !pop_mem) begin
      count_nxt = count_r + 1'b1;
    end else if (!push && pop_mem) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, count and ready
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
      end
      if (pop_mem) begin
        rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
      end
      count_r <= count_nxt;
      in_ready_r <= (count_nxt != FULL_CNT);
    end
  end

  // Output stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data_r <= '0;
      out_valid_r <= 1'b0;
    end else if (pop_mem) begin
      out_data_r <= mem[rd_ptr_r];
      out_valid_r <= 1'b1;
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

  assign in_ready = in_ready_r;
  assign out_data = out_data_r;
  assign out_valid = out_valid_r;

  // A full store never offers room
  AST_FULL_NO_ROOM: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count_r == FULL_CNT) |-> !in_ready)
    else $error("FIFO full but ready high");

endmodule : spias_fifo

// ---- verif/spias_peer.sv ----
// Behavioural SPI slave standing at the far end of the serial port.
`timescale 1ns/1ns
module spias_peer (
  input wire logic sck,
  input wire logic ws_n,
  input wire logic mosi,
  input wire logic [4:0] nbits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] last,
  output logic [4:0] nb_last,
  output realtime per
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] cap; // Bits taken in this frame
  logic [15:0] sh; // Reply shifter, MSB on the line
  logic [4:0] nb; // Rises seen in this frame
  realtime t_rise; // Time of the previous rise
  initial begin
    miso = 1'b0;
    last = 16'h0000;
    nb_last = 5'h00;
    per = 0.0;
    t_rise = 0.0;
    cap = 16'h0000;
    sh = 16'h0000;
    nb = 5'h00;
  end
  // First bit goes out at select, same frame length as the master
  always @(negedge ws_n) begin
    sh = reply << (5'h10 - nbits);
    miso = sh[15];
    nb = 5'h00;
    cap = 16'h0000;
  end
  // Sample on rises; note the bit period, far end never clocks the link
  always @(posedge sck) begin
    if (!ws_n) begin
      cap = {cap[14:0], mosi};
      nb = nb + 5'h01;
      per = $realtime - t_rise;
      t_rise = $realtime;
    end
  end
  // Change data on falls
  always @(negedge sck) begin
    if (!ws_n) begin
      sh = sh << 1;
      miso = sh[15];
    end
  end
  // Deselected: report the frame and stop showing the last bit
  always @(posedge ws_n) begin
    last = cap;
    nb_last = nb;
    miso = ~miso;
  end
endmodule : spias_peer

// ---- verif/spias_top_tb.sv ----
// Self-checking bench for the serial port with its audio framing mode.
`timescale 1ns/1ns
module spias_top_tb;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic ref_clk, rst_n, enable, audio_mode, master_mode, audio_tx, slot_32, mclk_enable;
  logic [2:0] rate_sel;
  logic [4:0] frame_len;
  logic [1:0] audio_std, data_len;
  logic [7:0] rate_div;
  logic [31:0] tx_data, rx_data;
  logic tx_valid, tx_ready, rx_valid, rx_ack, one_line;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ws_out, ws_oe, mclk_out;
  logic peer_miso;
  logic [15:0] peer_last, reply;
  logic [4:0] peer_nb;
  realtime peer_per, ws_t0, ws_t1, mk_t0, mk_t1;
  int err_total, total_checks, cyc, acc, i, s;
  typedef struct {logic [4:0] fl; logic [2:0] rs; logic [31:0] tx; logic [15:0] rp;} spias_row_t;
  spias_row_t rows [4] = '{'{5'h04, 3'h0, 32'h0000000A, 16'h0005},
    '{5'h10, 3'h1, 32'h0000C3A5, 16'h5A3C}, '{5'h09, 3'h2, 32'h00000155, 16'h00AA},
    '{5'h10, 3'h7, 32'h00008001, 16'hFFFE}};

  ////////////////////////////////////////////////////////////////////////////
  spias_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .enable(enable), .audio_mode(audio_mode),
    .master_mode(master_mode), .one_line(one_line), .one_line_tx(1'b1), .audio_tx(audio_tx),
    .rate_sel(rate_sel), .frame_len(frame_len), .audio_std(audio_std), .slot_32(slot_32),
    .data_len(data_len), .rate_div(rate_div), .mclk_enable(mclk_enable), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ack(rx_ack), .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(1'b0),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(peer_miso), .miso_out(miso_out),
    .miso_oe(miso_oe), .ws_in(1'b1), .ws_out(ws_out), .ws_oe(ws_oe), .mclk_out(mclk_out));
  spias_peer peer (.sck(sck_out), .ws_n(ws_out), .mosi(mosi_out), .nbits(frame_len),
    .reply(reply), .miso(peer_miso), .last(peer_last), .nb_last(peer_nb), .per(peer_per));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, edge timestamps and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ws_out) begin
    ws_t0 = ws_t1;
    ws_t1 = $realtime;
  end
  always @(posedge mclk_out) begin
    mk_t0 = mk_t1;
    mk_t1 = $realtime;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Waits for one select-low frame to complete, bounded
  task run_frame;
    int k;
    k = 0;
    while (ws_out !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    while (ws_out !== 1'b1 && k < 6000) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (3) @(negedge ref_clk);
  endtask : run_frame
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, enable, audio_mode, audio_tx, slot_32, mclk_enable, tx_valid, rx_ack} = '0;
    {rate_sel, frame_len, audio_std, data_len, rate_div, tx_data, one_line} = '0;
    {err_total, total_checks, cyc, acc} = '0;
    ws_t0 = 0.0;
    ws_t1 = 0.0;
    mk_t0 = 0.0;
    mk_t1 = 0.0;
    master_mode = 1'b1;
    reply = 16'h0000;
    repeat (20) @(negedge ref_clk);
    // Reset values
    check("tx_ready", tx_ready, 32'h1);
    check("rx_valid", rx_valid, 32'h0);
    check("oe", {sck_oe, mosi_oe, ws_oe, ws_out, mclk_out}, 32'h2);
    rst_n = 1'b1;
    // Full-duplex master frames: lengths and bit clock rates
    foreach (rows[r]) begin
      frame_len = rows[r].fl;
      rate_sel = rows[r].rs;
      reply = rows[r].rp;
      tx_data = rows[r].tx;
      tx_valid = 1'b1;
      @(negedge ref_clk);
      tx_valid = 1'b0;
      enable = 1'b1;
      run_frame();
      enable = 1'b0;
      @(negedge ref_clk);
      check("bits", 32'(peer_nb), 32'(rows[r].fl));
      check("mosi word", 32'(peer_last), rows[r].tx & ((32'h1 << rows[r].fl) - 32'h1));
      check("rx_data", rx_data, 32'(rows[r].rp) & ((32'h1 << rows[r].fl) - 32'h1));
      check("bit period", 32'(int'(peer_per)), 32'(100 << rows[r].rs));
      check("sck_oe", 32'(sck_oe), 32'h0);
    end
    check("rx_valid set", rx_valid, 32'h1);
    rx_ack = 1'b1;
    @(negedge ref_clk);
    rx_ack = 1'b0;
    @(negedge ref_clk);
    check("rx_valid ack", rx_valid, 32'h0);
    // Fill the FIFO while the port is stopped, until it refuses
    frame_len = 5'h10;
    rate_sel = 3'h0;
    for (i = 0; i < 12; i++) begin
      tx_data = 32'(acc);
      tx_valid = 1'b1;
      if (tx_ready === 1'b1) acc++;
      @(negedge ref_clk);
    end
    tx_valid = 1'b0;
    check("fifo words", 32'(acc), 32'(spias_pkg::FIFO_DEPTH + 1));
    check("full ready", tx_ready, 32'h0);
    // Drain back to back and keep order
    enable = 1'b1;
    for (i = 0; i < acc; i++) begin
      run_frame();
      check("drain word", 32'(peer_last), 32'(i));
    end
    enable = 1'b0;
    check("empty ready", tx_ready, 32'h1);
    // One-line transmit: the word goes out and nothing is received
    one_line = 1'b1;
    rx_ack = 1'b1;
    tx_data = 32'h00001234;
    tx_valid = 1'b1;
    @(negedge ref_clk);
    {rx_ack, tx_valid, enable} = 3'b001;
    run_frame();
    enable = 1'b0;
    check("one-line word", 32'(peer_last), 32'h00001234);
    check("one-line rx", 32'(rx_valid), 32'h0);
    one_line = 1'b0;
    // Audio master: each standard, frame rate and master clock ratio
    audio_mode = 1'b1;
    audio_tx = 1'b1;
    mclk_enable = 1'b1;
    for (s = 0; s < 4; s++) begin
      audio_std = 2'(s);
      slot_32 = s[0];
      data_len = 2'(s);
      rate_div = 8'(s + 1);
      enable = 1'b1;
      repeat (512 * (s + 1) * 3 + 20) @(negedge ref_clk);
      check("ws period", 32'(int'(ws_t1 - ws_t0)), 32'(25600 * (s + 1)));
      check("mclk period", 32'(int'(mk_t1 - mk_t0)), 32'(100 * (s + 1)));
      check("ws_oe", 32'(ws_oe), 32'h1);
      enable = 1'b0;
      repeat (5) @(negedge ref_clk);
    end
    // Reset in mid-run while the audio master is busy, then restart
    enable = 1'b1;
    repeat (100) @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    check("reset oe", {sck_oe, ws_oe, miso_oe, mosi_oe}, 32'h0);
    check("reset pins", {tx_ready, ws_out, sck_out, mclk_out, mosi_out}, 32'h18);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("restart oe", {ws_oe, sck_oe, mosi_oe, miso_oe}, 32'hE);
    finish_test();
  end
endmodule : spias_top_tb
